// ==== logic/pps_defines.svh ====
// register offsets, field positions, reset values and key bytes
`ifndef PPS_DEFINES_SVH
`define PPS_DEFINES_SVH
`define PPS_ADDR_W 8
`define PPS_DATA_W 16
`define PPS_SEL_W 5
`define PPS_NUM_PINS 26
`define PPS_FUNC_W 32
`define PPS_IN_RST 5'h1F
`define PPS_OUT_RST 5'h00
`define PPS_PARK_PIN 5'h1F
`define PPS_LANE0_LSB 0
`define PPS_LANE1_LSB 8
`define PPS_IN_REG0 8'h00
`define PPS_IN_REG1 8'h01
`define PPS_IN_REG3 8'h03
`define PPS_IN_REG4 8'h04
`define PPS_IN_REG7 8'h07
`define PPS_IN_REG8 8'h08
`define PPS_IN_REG9 8'h09
`define PPS_IN_REG11 8'h0B
`define PPS_IN_REG18 8'h12
`define PPS_IN_REG19 8'h13
`define PPS_IN_REG20 8'h14
`define PPS_IN_REG21 8'h15
`define PPS_IN_REG22 8'h16
`define PPS_IN_REG23 8'h17
`define PPS_OUT_BASE 8'h20
`define PPS_OSC_CTRL 8'h40
`define PPS_LOCK_BIT 6
`define PPS_KEY_ONE 8'h46
`define PPS_KEY_TWO 8'h57
`define PPS_FUNC_NULL 5'h00
`define PPS_FUNC_LO_LAST 5'h0C
`define PPS_FUNC_HI_FIRST 5'h12
`define PPS_FUNC_HI_LAST 5'h16
`define PPS_FUSE_DEFAULT 1'b1
`endif

// ==== logic/pps_pkg.sv ====
// types shared by the pin select block and its bench
package pps_pkg;
   typedef logic [4:0] pps_sel_t;

   // register bus request from the software side
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [15:0] wdata;
   } pps_bus_req_t;

   // remappable peripheral inputs, index into o_periph_in
   typedef enum logic [4:0] {
      IN_EXT_IRQ_ONE = 5'h00, IN_EXT_IRQ_TWO = 5'h01,
      IN_TIMER2_EXT_CLOCK = 5'h02, IN_TIMER3_EXT_CLOCK = 5'h03,
      IN_TIMER4_EXT_CLOCK = 5'h04, IN_TIMER5_EXT_CLOCK = 5'h05,
      IN_CAPTURE_ONE = 5'h06, IN_CAPTURE_TWO = 5'h07,
      IN_CAPTURE_THREE = 5'h08, IN_CAPTURE_FOUR = 5'h09,
      IN_CAPTURE_FIVE = 5'h0A, IN_COMPARE_FAULT_A = 5'h0B,
      IN_COMPARE_FAULT_B = 5'h0C, IN_UART1_RECEIVE = 5'h0D,
      IN_UART1_CLEAR_TO_SEND = 5'h0E, IN_UART2_RECEIVE = 5'h0F,
      IN_UART2_CLEAR_TO_SEND = 5'h10, IN_SPI1_DATA_IN = 5'h11,
      IN_SPI1_CLOCK_IN = 5'h12, IN_SPI1_SELECT_IN = 5'h13,
      IN_SPI2_DATA_IN = 5'h14, IN_SPI2_CLOCK_IN = 5'h15,
      IN_SPI2_SELECT_IN = 5'h16
   } pps_in_t;

   // key sequence tracker states
   typedef enum logic [2:0] {
      KEY_IDLE = 3'b001,
      KEY_GOT_ONE = 3'b010,
      KEY_GOT_TWO = 3'b100
   } pps_key_state_t;
endpackage

// ==== logic/pps_pin_select.sv ====
// remappable peripheral pin select: selector registers, lock and muxes
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`include "pps_defines.svh"

// Overview of operation
// - each input has 5-bit field selecting pin
// - input register holds one or two selector fields
// - field accepts only supported pin numbers
// - twenty-three listed peripheral inputs are remappable
// - each pin has 5-bit output function field
// - output value zero disconnects the pin
// - function numbers decode to listed peripheral outputs
// - reset puts null function on every pin
// - input and output maps are independent
// - one pin many inputs, one output many pins
// - no lockout on any mapping combination
// - locked selector writes complete but change nothing
// - lock is bit 6 of oscillator control
// - lock changes only after 46h, 57h keys
// - lock holds until next key sequence
// - shadow mismatch raises configuration mismatch reset
// - one-shot fuse blocks clearing a set lock
// - in one-shot mode only reset clears lock
// - fuse default one-shot, programmed zero unlimited
// - reset inputs to pin 31, outputs zero
// - lock comes out of reset unlocked
module pps_pin_select #(
   parameter int NUM_PINS = `PPS_NUM_PINS
) (
   input wire logic i_clock,
   input wire logic i_nrst,
   input pps_pkg::pps_bus_req_t i_bus,
   output logic [15:0] o_rdata,
   input wire logic i_one_shot_lock_fuse,
   input wire logic [NUM_PINS-1:0] i_pin_in,
   input wire logic [`PPS_FUNC_W-1:0] i_func_out,
   output logic [22:0] o_periph_in,
   output logic [NUM_PINS-1:0] o_pin_out,
   output logic [NUM_PINS-1:0] o_pin_oe,
   output logic o_map_write_lock,
   output logic o_cfg_mismatch_rst
);
   import pps_pkg::*;

   localparam int NUM_IN = 23;
   localparam int NUM_OUT_REGS = (NUM_PINS + 1) / 2;

   pps_sel_t in_sel_q [NUM_IN];
   pps_sel_t in_shadow_q [NUM_IN];
   pps_sel_t out_sel_q [NUM_PINS];
   pps_sel_t out_shadow_q [NUM_PINS];
   logic [NUM_IN-1:0] in_wr;
   logic [NUM_PINS-1:0] out_wr;
   logic [NUM_IN-1:0] in_diff;
   logic [NUM_PINS-1:0] out_diff;
   logic [NUM_PINS-1:0] pin_s1_q;
   logic [NUM_PINS-1:0] pin_s2_q;
   logic [NUM_PINS-1:0] pin_s3_q;
   logic [NUM_PINS-1:0] pin_filt_q;
   logic lock_q;
   logic fuse_q;
   pps_key_state_t key_q;
   pps_key_state_t key_d;
   logic osc_wr;
   logic key_one_wr;
   logic key_two_wr;
   logic lock_wr;
   logic [15:0] rd_d;
   logic [15:0] in_rd [NUM_IN];
   logic [15:0] out_rd [NUM_PINS];

   // register address and lane (0 low, 1 high) of each input field
   function automatic logic [8:0] in_loc(input int idx);
      logic [8:0] loc;
      loc = 9'h000;
      case (idx)
         int'(IN_EXT_IRQ_ONE): loc = {`PPS_IN_REG0, 1'b1};
         int'(IN_EXT_IRQ_TWO): loc = {`PPS_IN_REG1, 1'b0};
         int'(IN_TIMER2_EXT_CLOCK): loc = {`PPS_IN_REG3, 1'b0};
         int'(IN_TIMER3_EXT_CLOCK): loc = {`PPS_IN_REG3, 1'b1};
         int'(IN_TIMER4_EXT_CLOCK): loc = {`PPS_IN_REG4, 1'b0};
         int'(IN_TIMER5_EXT_CLOCK): loc = {`PPS_IN_REG4, 1'b1};
         int'(IN_CAPTURE_ONE): loc = {`PPS_IN_REG7, 1'b0};
         int'(IN_CAPTURE_TWO): loc = {`PPS_IN_REG7, 1'b1};
         int'(IN_CAPTURE_THREE): loc = {`PPS_IN_REG8, 1'b0};
         int'(IN_CAPTURE_FOUR): loc = {`PPS_IN_REG8, 1'b1};
         int'(IN_CAPTURE_FIVE): loc = {`PPS_IN_REG9, 1'b0};
         int'(IN_COMPARE_FAULT_A): loc = {`PPS_IN_REG11, 1'b0};
         int'(IN_COMPARE_FAULT_B): loc = {`PPS_IN_REG11, 1'b1};
         int'(IN_UART1_RECEIVE): loc = {`PPS_IN_REG18, 1'b0};
         int'(IN_UART1_CLEAR_TO_SEND): loc = {`PPS_IN_REG18, 1'b1};
         int'(IN_UART2_RECEIVE): loc = {`PPS_IN_REG19, 1'b0};
         int'(IN_UART2_CLEAR_TO_SEND): loc = {`PPS_IN_REG19, 1'b1};
         int'(IN_SPI1_DATA_IN): loc = {`PPS_IN_REG20, 1'b0};
         int'(IN_SPI1_CLOCK_IN): loc = {`PPS_IN_REG20, 1'b1};
         int'(IN_SPI1_SELECT_IN): loc = {`PPS_IN_REG21, 1'b0};
         int'(IN_SPI2_DATA_IN): loc = {`PPS_IN_REG22, 1'b0};
         int'(IN_SPI2_CLOCK_IN): loc = {`PPS_IN_REG22, 1'b1};
         int'(IN_SPI2_SELECT_IN): loc = {`PPS_IN_REG23, 1'b0};
         default: loc = 9'h1FE;
      endcase
      return loc;
   endfunction

   // pick the selector lane out of a write word
   function automatic pps_sel_t lane_val(input logic [15:0] w,
                                         input logic lane);
      return lane ? w[`PPS_LANE1_LSB +: 5] : w[`PPS_LANE0_LSB +: 5];
   endfunction

   // input field accepts an existing pin or the park value only
   function automatic logic in_ok(input pps_sel_t v);
      return (int'(v) < NUM_PINS) || (v == `PPS_PARK_PIN);
   endfunction

   // output function numbers that name a peripheral output
   function automatic logic func_ok(input pps_sel_t v);
      return ((v != `PPS_FUNC_NULL) && (v <= `PPS_FUNC_LO_LAST)) ||
             ((v >= `PPS_FUNC_HI_FIRST) &&
              (v <= `PPS_FUNC_HI_LAST));
   endfunction

   // output field accepts null or a defined function number
   function automatic logic out_ok(input pps_sel_t v);
      return (v == `PPS_FUNC_NULL) || func_ok(v);
   endfunction

   // writes to the oscillator control register
   assign osc_wr = i_bus.wr && (i_bus.addr == `PPS_OSC_CTRL);
   // the two key bytes, written to the low byte of oscillator control
   assign key_one_wr = osc_wr && (i_bus.wdata[7:0] == `PPS_KEY_ONE);
   assign key_two_wr = osc_wr && (i_bus.wdata[7:0] == `PPS_KEY_TWO);
   // third write of a complete key sequence carries the new lock value;
   // a key byte there restarts the sequence instead of moving the lock
   assign lock_wr = osc_wr && (key_q == KEY_GOT_TWO) &&
                    !key_one_wr && !key_two_wr;

   // key tracker: any other write restarts the sequence, reads do not
   always_comb begin
      key_d = key_q;
      if (i_bus.wr) begin
         key_d = KEY_IDLE;
         case (key_q)
            KEY_IDLE: begin
               if (key_one_wr) begin
                  key_d = KEY_GOT_ONE;
               end
            end
            KEY_GOT_ONE: begin
               if (key_one_wr) begin
                  key_d = KEY_GOT_ONE;
               end else if (key_two_wr) begin
                  key_d = KEY_GOT_TWO;
               end
            end
            KEY_GOT_TWO: begin
               if (key_one_wr) begin
                  key_d = KEY_GOT_ONE;
               end
            end
            default: begin
               key_d = KEY_IDLE;
            end
         endcase
      end
   end

   // key tracker state
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         key_q <= KEY_IDLE;
      end else begin
         key_q <= key_d;
      end
   end

   // one-shot fuse is sampled while reset is held
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         fuse_q <= i_one_shot_lock_fuse;
      end
   end

   // map write lock, bit 6 of the oscillator control register
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         lock_q <= 1'b0;
      end else if (lock_wr) begin
         if (i_bus.wdata[`PPS_LOCK_BIT]) begin
            lock_q <= 1'b1;
         end else if (!(fuse_q && lock_q)) begin
            lock_q <= 1'b0;
         end
      end
   end

   // per-input selector fields and their write decode
   for (genvar i = 0; i < NUM_IN; i++) begin : g_in
      localparam logic [8:0] LOC = in_loc(i);
      pps_sel_t in_val;
      // this field's lane of the write word
      assign in_val = lane_val(i_bus.wdata, LOC[0]);
      assign in_wr[i] = i_bus.wr && !lock_q &&
                        (i_bus.addr == LOC[8:1]) &&
                        in_ok(in_val);
      // selector register, any pin for any input
      always_ff @(posedge i_clock) begin
         if (!i_nrst) begin
            in_sel_q[i] <= `PPS_IN_RST;
         end else if (in_wr[i]) begin
            in_sel_q[i] <= lane_val(i_bus.wdata, LOC[0]);
         end
      end
      // shadow copy follows every legal write
      always_ff @(posedge i_clock) begin
         if (!i_nrst) begin
            in_shadow_q[i] <= `PPS_IN_RST;
         end else if (in_wr[i]) begin
            in_shadow_q[i] <= lane_val(i_bus.wdata, LOC[0]);
         end
      end
      assign in_diff[i] = (in_sel_q[i] != in_shadow_q[i]);
      // read lane of this field, zero when another register is addressed
      always_comb begin
         in_rd[i] = 16'h0000;
         if (i_bus.addr == LOC[8:1]) begin
            if (LOC[0]) begin
               in_rd[i][`PPS_LANE1_LSB +: 5] = in_sel_q[i];
            end else begin
               in_rd[i][`PPS_LANE0_LSB +: 5] = in_sel_q[i];
            end
         end
      end
      // route the chosen filtered pin, absent pins read low
      always_ff @(posedge i_clock) begin
         if (!i_nrst) begin
            o_periph_in[i] <= 1'b0;
         end else if (int'(in_sel_q[i]) < NUM_PINS) begin
            o_periph_in[i] <= pin_filt_q[in_sel_q[i]];
         end else begin
            o_periph_in[i] <= 1'b0;
         end
      end
   end

   // per-pin output selector fields, synchroniser and driver
   for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
      localparam logic [7:0] ADDR = 8'(`PPS_OUT_BASE + p / 2);
      localparam logic LANE = 1'(p % 2);
      pps_sel_t out_val;
      // this pin's lane of the write word
      assign out_val = lane_val(i_bus.wdata, LANE);
      assign out_wr[p] = i_bus.wr && !lock_q && (i_bus.addr == ADDR) &&
                         out_ok(out_val);
      // output selector register
      always_ff @(posedge i_clock) begin
         if (!i_nrst) begin
            out_sel_q[p] <= `PPS_OUT_RST;
         end else if (out_wr[p]) begin
            out_sel_q[p] <= lane_val(i_bus.wdata, LANE);
         end
      end
      // shadow copy of the output selector
      always_ff @(posedge i_clock) begin
         if (!i_nrst) begin
            out_shadow_q[p] <= `PPS_OUT_RST;
         end else if (out_wr[p]) begin
            out_shadow_q[p] <= lane_val(i_bus.wdata, LANE);
         end
      end
      assign out_diff[p] = (out_sel_q[p] != out_shadow_q[p]);
      // read lane of this pin's field, zero for other addresses
      always_comb begin
         out_rd[p] = 16'h0000;
         if (i_bus.addr == ADDR) begin
            if (LANE) begin
               out_rd[p][`PPS_LANE1_LSB +: 5] = out_sel_q[p];
            end else begin
               out_rd[p][`PPS_LANE0_LSB +: 5] = out_sel_q[p];
            end
         end
      end
      // pin drive: chosen function, or released for null
      always_ff @(posedge i_clock) begin
         if (!i_nrst) begin
            o_pin_out[p] <= 1'b0;
            o_pin_oe[p] <= 1'b0;
         end else if (func_ok(out_sel_q[p])) begin
            o_pin_out[p] <= i_func_out[out_sel_q[p]];
            o_pin_oe[p] <= 1'b1;
         end else begin
            o_pin_out[p] <= 1'b0;
            o_pin_oe[p] <= 1'b0;
         end
      end
      // three-stage synchroniser, change taken when stages 2 and 3 agree
      always_ff @(posedge i_clock) begin
         if (!i_nrst) begin
            pin_s1_q[p] <= 1'b0;
            pin_s2_q[p] <= 1'b0;
            pin_s3_q[p] <= 1'b0;
            pin_filt_q[p] <= 1'b0;
         end else begin
            pin_s1_q[p] <= i_pin_in[p];
            pin_s2_q[p] <= pin_s1_q[p];
            pin_s3_q[p] <= pin_s2_q[p];
            if (pin_s2_q[p] == pin_s3_q[p]) begin
               pin_filt_q[p] <= pin_s3_q[p];
            end
         end
      end
   end

   // read mux: selector fields in their lanes, lock in bit 6 of oscillator control, other bits zero
   always_comb begin
      rd_d = 16'h0000;
      for (int i = 0; i < NUM_IN; i++) begin
         rd_d = rd_d | in_rd[i];
      end
      for (int p = 0; p < NUM_PINS; p++) begin
         rd_d = rd_d | out_rd[p];
      end
      if (i_bus.addr == `PPS_OSC_CTRL) begin
         rd_d[`PPS_LOCK_BIT] = lock_q;
      end
   end

   // read data stands only in the cycle after the read strobe
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         o_rdata <= 16'h0000;
      end else if (i_bus.rd) begin
         o_rdata <= rd_d;
      end else begin
         o_rdata <= 16'h0000;
      end
   end

   // configuration mismatch reset request on any shadow difference
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         o_cfg_mismatch_rst <= 1'b0;
      end else begin
         o_cfg_mismatch_rst <= (|in_diff) || (|out_diff);
      end
   end

   assign o_map_write_lock = lock_q;

   // last output register address, kept for address range checks
   localparam logic [7:0] OUT_LAST = 8'(`PPS_OUT_BASE + NUM_OUT_REGS - 1);
endmodule

// ==== tb/pps_pin_select_props.sv ====
// port-level assertions for the pin select block
module pps_checker import pps_pkg::*; #(
   parameter int NUM_PINS = 26
) (
   input wire logic i_clock,
   input wire logic i_nrst,
   input pps_pkg::pps_bus_req_t i_bus,
   input wire logic [15:0] o_rdata,
   input wire logic i_one_shot_lock_fuse,
   input wire logic [22:0] o_periph_in,
   input wire logic [NUM_PINS-1:0] o_pin_oe,
   input wire logic o_map_write_lock,
   input wire logic o_cfg_mismatch_rst
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_nrst);
   logic wr_osc, key_one, key_two, wr_out;
   // decode of writes to the oscillator control and output maps
   assign wr_osc = i_bus.wr && i_bus.addr == 8'h40;
   assign key_one = wr_osc && i_bus.wdata[7:0] == 8'h46;
   assign key_two = wr_osc && i_bus.wdata[7:0] == 8'h57;
   assign wr_out = i_bus.wr && i_bus.addr >= 8'h20 && i_bus.addr <= 8'h2C;
   // two key writes then the lock write, one idle cycle apart
   sequence key_s;
      key_one ##1 !i_bus.wr ##1 key_two ##1 !i_bus.wr
         ##1 (wr_osc && !key_one && !key_two);
   endsequence
   rdata_idle_a: assert property (!$past(i_bus.rd) |-> o_rdata == 16'h0000)
      else $error("read data not zero outside a read answer");
   lock_read_a: assert property (i_bus.rd && i_bus.addr == 8'h40 |=>
      o_rdata == {9'h000, $past(o_map_write_lock), 6'h00})
      else $error("lock readback wrong");
   reset_open_a: assert property ($rose(i_nrst) |-> !o_map_write_lock [*3])
      else $error("lock not clear after reset");
   reset_null_a: assert property ($rose(i_nrst) |->
      (o_pin_oe == '0 && o_periph_in == '0) [*2])
      else $error("maps not idle after reset");
   lock_change_a: assert property ($changed(o_map_write_lock) |->
      $past(wr_osc) && !$past(key_one) && !$past(key_two))
      else $error("lock moved without a lock write");
   lock_set_a: assert property (key_s ##0 i_bus.wdata[6] |=> o_map_write_lock)
      else $error("key sequence did not set lock");
   lock_clear_a: assert property (key_s ##0 !i_bus.wdata[6]
      && !i_one_shot_lock_fuse |=> !o_map_write_lock)
      else $error("key sequence did not clear lock");
   one_shot_a: assert property (o_map_write_lock && i_one_shot_lock_fuse
      |=> o_map_write_lock)
      else $error("one-shot lock was cleared");
   oe_change_a: assert property ($changed(o_pin_oe) |-> $past(wr_out, 2)
      && !$past(o_map_write_lock, 2))
      else $error("pin enable moved without an open write");
   mismatch_quiet_a: assert property (!o_cfg_mismatch_rst)
      else $error("mismatch reset raised");
endmodule

// ==== tb/pps_far_side.sv ====
// far side stand-in: pin levels and peripheral output functions
module pps_far_side (
   input wire logic i_clock,
   input wire logic [31:0] i_seed,
   output logic [25:0] o_pins,
   output logic [31:0] o_funcs
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] seed_q;
   // new levels taken each clock, steady while the seed stands
   always_ff @(posedge i_clock) begin
      seed_q <= i_seed;
   end
   // pins and functions are unrelated patterns of the same seed
   assign o_pins = seed_q[25:0] ^ {seed_q[31:26], 20'h5A5A5};
   assign o_funcs = ~seed_q;
endmodule

// ==== tb/remappable_peripheral_pin_select_test.sv ====
// self-checking bench for the remappable pin select block
module remappable_peripheral_pin_select_test import pps_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clock = 0, i_nrst = 0, i_one_shot_lock_fuse = 1;
   pps_bus_req_t i_bus = '0;
   logic [15:0] o_rdata;
   logic [22:0] o_periph_in;
   logic [25:0] i_pin_in, o_pin_out, o_pin_oe;
   logic [31:0] i_func_out, pat = 32'h0, seed = 32'h15768A4E;
   logic o_map_write_lock, o_cfg_mismatch_rst;
   int num_errors = 0, cmp_count = 0, cycles = 0, kst = 0, mlock = 0;
   int mreg[256], msk[256];
   int ia[23] = '{0,1,3,3,4,4,7,7,8,8,9,11,11,18,18,19,19,20,20,21,22,22,23};
   int il[23] = '{1,0,0,1,0,1,0,1,0,1,0,0,1,0,1,0,1,0,1,0,0,1,0};
   pps_far_side far_u (.i_clock, .i_seed(pat), .o_pins(i_pin_in),
      .o_funcs(i_func_out));
   pps_pin_select dut_u (.i_clock, .i_nrst, .i_bus, .o_rdata,
      .i_one_shot_lock_fuse, .i_pin_in, .i_func_out, .o_periph_in,
      .o_pin_out, .o_pin_oe, .o_map_write_lock, .o_cfg_mismatch_rst);
   // clock and hang guard
   initial forever #4 i_clock = ~i_clock;
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         close_out();
      end
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic do_reset();
      i_nrst <= 0;
      repeat (3) @(posedge i_clock);
      i_nrst <= 1;
      mlock = 0;
      kst = 0;
      foreach (mreg[a]) mreg[a] = (a < 32) ? msk[a] : 0;
   endtask
   // one bus write, then the model: lanes first, key tracker after
   task automatic wr(int a, int d);
      int v;
      i_bus <= '{1'b1, 1'b0, a[7:0], d[15:0]};
      @(posedge i_clock);
      i_bus <= '0;
      if (mlock == 0 && msk[a] != 0)
         for (int l = 0; l < 16; l += 8) begin
            v = (d >> l) & 31;
            if (msk[a][l] && (a < 32 ? (v < 26 || v == 31)
               : (v < 13 || (v > 17 && v < 23))))
               mreg[a] = mreg[a] & ~(31 << l) | v << l;
         end
      if (a != 8'h40) kst = 0;
      else if (d[7:0] == 8'h46) kst = 1;
      else if (kst == 1 && d[7:0] == 8'h57) kst = 2;
      else begin
         if (kst == 2 && d[7:0] != 8'h57 &&
            (d[6] || !(i_one_shot_lock_fuse && mlock)))
            mlock = d[6];
         kst = 0;
      end
      @(posedge i_clock);
   endtask
   task automatic rd(int a, output logic [15:0] got);
      i_bus <= '{1'b0, 1'b1, a[7:0], 16'h0000};
      @(posedge i_clock);
      i_bus <= '0;
      #1 got = o_rdata;
      @(posedge i_clock);
   endtask
   task automatic key(int set);
      wr(8'h40, 8'h46);
      wr(8'h40, 8'h57);
      wr(8'h40, set ? 8'h40 : 8'h00);
   endtask
   // read addresses 00h to 4Fh, then check both maps with fresh pin levels
   task automatic verify(string name);
      logic [15:0] got;
      int s;
      for (int a = 0; a < 8'h50; a++) begin
         rd(a, got);
         chk("register", a == 8'h40 ? mlock << 6 : mreg[a], got);
      end
      pat <= xs();
      repeat (10) @(posedge i_clock);
      for (int i = 0; i < 23; i++) begin
         s = (mreg[ia[i]] >> (il[i] * 8)) & 31;
         chk("input map", s < 26 ? i_pin_in[s] : 0, o_periph_in[i]);
      end
      for (int p = 0; p < 26; p++) begin
         s = (mreg[32 + p / 2] >> (p % 2 * 8)) & 31;
         chk("pin enable", s != 0, o_pin_oe[p]);
         if (s != 0)
            chk("pin data", i_func_out[s], o_pin_out[p]);
         else
            chk("pin idle", 0, o_pin_out[p]);
      end
      chk("lock", mlock, o_map_write_lock);
      chk("mismatch", 0, o_cfg_mismatch_rst);
      $display("test %s done", name);
   endtask
   task automatic close_out();
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // main sequence
   initial begin
      foreach (ia[i]) msk[ia[i]] |= il[i] ? 16'h1F00 : 16'h001F;
      for (int k = 0; k < 13; k++) msk[32 + k] = 16'h1F1F;
      do_reset();
      verify("reset values");
      repeat (150) wr(xs() % 8'h50, xs());
      verify("random map");
      key(1);
      repeat (40) wr(xs() % 8'h30, xs());
      key(0);
      verify("one-shot lock");
      do_reset();
      verify("reset reopens");
      i_one_shot_lock_fuse <= 0;
      do_reset();
      key(1);
      wr(8'h40, 8'h46);
      wr(8'h05, 0);
      wr(8'h40, 8'h57);
      wr(8'h40, 0);
      verify("broken key");
      key(0);
      for (int k = 0; k < 13; k++) wr(32 + k, (2 * k + 1) << 8 | 2 * k);
      verify("all codes");
      wr(8'h12, 0);
      for (int k = 0; k < 13; k++) wr(32 + k, 16'h0303);
      repeat (30) wr(xs() % 8'h30, xs());
      verify("shared pins");
      close_out();
   end
endmodule
bind pps_pin_select pps_checker #(.NUM_PINS(NUM_PINS)) chk_u (.i_clock,
   .i_nrst, .i_bus, .o_rdata, .i_one_shot_lock_fuse, .o_periph_in,
   .o_pin_oe, .o_map_write_lock, .o_cfg_mismatch_rst);
